// >>> rtl/ext_mem_pkg.sv
// constants shared by the multiplexed external memory timing controller
package ext_mem_pkg;
	// timing register location and reset value (slowest settings)
	localparam logic [7:0] EXT_MEMORY_TIMING_ADDR  = 8'haa;
	localparam logic [7:0] EXT_MEMORY_TIMING_RESET = 8'hff;
	// timing register field positions
	localparam int SETUP_MSB  = 7;
	localparam int SETUP_LSB  = 6;
	localparam int WIDTH_MSB  = 5;
	localparam int WIDTH_LSB  = 2;
	localparam int HOLD_MSB   = 1;
	localparam int HOLD_LSB   = 0;
	// interface configuration field positions
	localparam int MODE_MSB   = 4;
	localparam int MODE_LSB   = 2;
	localparam int ALE_MSB    = 1;
	localparam int ALE_LSB    = 0;
	// interface configuration mode codes that reach off-chip memory
	localparam logic [2:0] MODE_SPLIT_NO_BANK = 3'h1;
	localparam logic [2:0] MODE_SPLIT_BANK    = 3'h2;
	localparam logic [2:0] MODE_EXT_ONLY      = 3'h3;
	// fixed overhead cycles added to every off-chip move
	localparam logic [4:0] OVERHEAD_CYCLES    = 5'h4;
	// access sequence phases
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ALE_HI,
		ST_ALE_LO,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD,
		ST_TAIL
	} phase_e;
endpackage : ext_mem_pkg

// >>> rtl/ext_mem_mux_timing.sv
// multiplexed external memory timing controller with its timing register
//
// Contract
// RULE_01: address stands setup-field cycles (0 to 3) before the read or write strobe.
// RULE_02: strobe lasts strobe-width code plus one cycles, one to sixteen.
// RULE_03: address stays driven hold-field cycles (0 to 3) after the strobe ends.
// RULE_04: 16-bit moves use multiplexed timing in modes 001/010/011, driving all sixteen bits.
// RULE_05: 8-bit moves in modes 001/011 drive only the low byte; high pins released.
// RULE_06: 8-bit moves in mode 010 take the high byte from the bank page register.
// RULE_07: after reset setup, width and hold sit at their slowest values.
// RULE_08: latch strobe high while low address shows, then low to freeze latch.
// RULE_09: latch strobe high and low phases each last code plus one cycles.
// RULE_10: each move takes four cycles beyond the sum of programmed timings.
// RULE_11: phases run latch high, latch low, setup, strobe, hold, in whole cycles.
`timescale 1ns/100ps
module ext_mem_mux_timing (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// special function register port
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	// configuration owned by the core
	input  wire logic [7:0]  ext_if_config,
	input  wire logic [7:0]  bank_page_register,
	// external move request from the core
	input  wire logic        move_valid,
	input  wire logic        move_write,
	input  wire logic        move_wide,
	input  wire logic [15:0] move_addr,
	input  wire logic [7:0]  move_wdata,
	output logic             move_busy,
	output logic             move_done,
	output logic      [7:0]  move_rdata,
	// external memory pins
	input  wire logic [7:0]  ad_in,
	output logic      [7:0]  ad_out,
	output logic             ad_oe,
	output logic      [7:0]  addr_hi_out,
	output logic             addr_hi_oe,
	output logic             ale_out,
	output logic             rd_out_n,
	output logic             wr_out_n
);

	logic [7:0]           ext_memory_timing_r;
	logic [7:0]           timing_snap_r;
	logic [1:0]           ale_snap_r;
	logic                 write_r;
	logic                 drive_hi_r;
	logic [7:0]           addr_lo_r;
	logic [7:0]           addr_hi_r;
	logic [7:0]           wdata_r;
	ext_mem_pkg::phase_e  state_r;
	ext_mem_pkg::phase_e  state_nxt;
	logic [4:0]           cnt_r;
	logic [4:0]           cnt_nxt;
	logic [2:0]           mode;
	logic                 mode_ok;
	logic                 accept;
	logic                 phase_end;

	// length of a phase in system clock cycles
	function automatic logic [4:0] phase_len(input ext_mem_pkg::phase_e st, input logic [7:0] tim,
		input logic [1:0] ale);
		case (st)
			ext_mem_pkg::ST_ALE_HI:  phase_len = {3'h0, ale} + 5'h1;                          // [RULE_09]
			ext_mem_pkg::ST_ALE_LO:  phase_len = {3'h0, ale} + 5'h1;                          // [RULE_09]
			ext_mem_pkg::ST_SETUP:   phase_len = {3'h0, tim[ext_mem_pkg::SETUP_MSB:ext_mem_pkg::SETUP_LSB]}; // [RULE_01]
			ext_mem_pkg::ST_STROBE:  phase_len = {1'b0, tim[ext_mem_pkg::WIDTH_MSB:ext_mem_pkg::WIDTH_LSB]} + 5'h1; // [RULE_02]
			ext_mem_pkg::ST_HOLD:    phase_len = {3'h0, tim[ext_mem_pkg::HOLD_MSB:ext_mem_pkg::HOLD_LSB]};   // [RULE_03]
			ext_mem_pkg::ST_TAIL:    phase_len = ext_mem_pkg::OVERHEAD_CYCLES;                // [RULE_10]
			default:                 phase_len = 5'h0;
		endcase
	endfunction : phase_len

	// fixed phase order; zero-length setup or hold is skipped
	function automatic ext_mem_pkg::phase_e phase_succ(input ext_mem_pkg::phase_e st);
		case (st)
			ext_mem_pkg::ST_ALE_HI:  phase_succ = ext_mem_pkg::ST_ALE_LO;
			ext_mem_pkg::ST_ALE_LO:  phase_succ = ext_mem_pkg::ST_SETUP;
			ext_mem_pkg::ST_SETUP:   phase_succ = ext_mem_pkg::ST_STROBE;
			ext_mem_pkg::ST_STROBE:  phase_succ = ext_mem_pkg::ST_HOLD;
			ext_mem_pkg::ST_HOLD:    phase_succ = ext_mem_pkg::ST_TAIL;
			default:                 phase_succ = ext_mem_pkg::ST_IDLE;
		endcase
	endfunction : phase_succ

	// only modes that reach off-chip memory start an access
	assign mode      = ext_if_config[ext_mem_pkg::MODE_MSB:ext_mem_pkg::MODE_LSB];
	assign mode_ok   = (mode == ext_mem_pkg::MODE_SPLIT_NO_BANK) || (mode == ext_mem_pkg::MODE_SPLIT_BANK) ||
		(mode == ext_mem_pkg::MODE_EXT_ONLY);                                                 // [RULE_04]
	assign accept    = (state_r == ext_mem_pkg::ST_IDLE) && move_valid && mode_ok;
	assign phase_end = (state_r != ext_mem_pkg::ST_IDLE) && (cnt_r == 5'h1);

	// sequencer next state: latch high, latch low, setup, strobe, hold, tail
	always_comb begin
		ext_mem_pkg::phase_e succ;
		succ      = ext_mem_pkg::ST_IDLE;
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		if (accept) begin
			state_nxt = ext_mem_pkg::ST_ALE_HI;                                                   // [RULE_11]
			cnt_nxt   = phase_len(ext_mem_pkg::ST_ALE_HI, ext_memory_timing_r,
				ext_if_config[ext_mem_pkg::ALE_MSB:ext_mem_pkg::ALE_LSB]);
		end else if (phase_end) begin
			succ = phase_succ(state_r);                                                          // [RULE_11]
			if ((succ != ext_mem_pkg::ST_IDLE) && (phase_len(succ, timing_snap_r, ale_snap_r) == 5'h0)) begin
				succ = phase_succ(succ);
			end
			state_nxt = succ;
			cnt_nxt   = phase_len(succ, timing_snap_r, ale_snap_r);
		end else if (state_r != ext_mem_pkg::ST_IDLE) begin
			cnt_nxt = cnt_r - 5'h1;
		end
	end

	// sequencer registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ext_mem_pkg::ST_IDLE;
			cnt_r   <= 5'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// timing register, written through the sfr port
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ext_memory_timing_r <= ext_mem_pkg::EXT_MEMORY_TIMING_RESET;                          // [RULE_07]
		end else if (sfr_wr && (sfr_addr == ext_mem_pkg::EXT_MEMORY_TIMING_ADDR)) begin
			ext_memory_timing_r <= sfr_wdata;
		end
	end

	// registered read; other addresses belong to other blocks and read zero here
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sfr_rdata <= 8'h00;
		end else begin
			sfr_rdata <= (sfr_addr == ext_mem_pkg::EXT_MEMORY_TIMING_ADDR) ? ext_memory_timing_r : 8'h00;
		end
	end

	// snapshot of settings and request so a mid-access write cannot tear the waveform
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			timing_snap_r <= ext_mem_pkg::EXT_MEMORY_TIMING_RESET;
			ale_snap_r    <= 2'h0;
			write_r       <= 1'b0;
			drive_hi_r    <= 1'b0;
			addr_lo_r     <= 8'h00;
			addr_hi_r     <= 8'h00;
			wdata_r       <= 8'h00;
		end else if (accept) begin
			timing_snap_r <= ext_memory_timing_r;
			ale_snap_r    <= ext_if_config[ext_mem_pkg::ALE_MSB:ext_mem_pkg::ALE_LSB];
			write_r       <= move_write;
			addr_lo_r     <= move_addr[7:0];
			wdata_r       <= move_wdata;
			if (move_wide) begin
				drive_hi_r <= 1'b1;                                                                  // [RULE_04]
				addr_hi_r  <= move_addr[15:8];
			end else if (mode == ext_mem_pkg::MODE_SPLIT_BANK) begin
				drive_hi_r <= 1'b1;                                                                  // [RULE_06]
				addr_hi_r  <= bank_page_register;
			end else begin
				drive_hi_r <= 1'b0;                                                                  // [RULE_05]
				addr_hi_r  <= 8'h00;
			end
		end
	end

	// latch strobe and low address/data bus, registered from the next phase
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ale_out <= 1'b0;
			ad_out  <= 8'h00;
			ad_oe   <= 1'b0;
		end else begin
			ale_out <= (state_nxt == ext_mem_pkg::ST_ALE_HI);                                     // [RULE_08]
			if ((state_nxt == ext_mem_pkg::ST_ALE_HI) || (state_nxt == ext_mem_pkg::ST_ALE_LO)) begin
				ad_out <= accept ? move_addr[7:0] : addr_lo_r;                                       // [RULE_08]
				ad_oe  <= 1'b1;
			end else if (write_r && ((state_nxt == ext_mem_pkg::ST_SETUP) ||
				(state_nxt == ext_mem_pkg::ST_STROBE) || (state_nxt == ext_mem_pkg::ST_HOLD))) begin
				ad_out <= wdata_r;                                                                   // [RULE_01]
				ad_oe  <= 1'b1;
			end else begin
				ad_out <= 8'h00;
				ad_oe  <= 1'b0;
			end
		end
	end

	// upper address pins: driven from latch phase until hold ends, else left to port latches
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			addr_hi_out <= 8'h00;
			addr_hi_oe  <= 1'b0;
		end else if (accept) begin
			addr_hi_out <= move_wide ? move_addr[15:8] :
				((mode == ext_mem_pkg::MODE_SPLIT_BANK) ? bank_page_register : 8'h00);            // [RULE_06]
			addr_hi_oe  <= move_wide || (mode == ext_mem_pkg::MODE_SPLIT_BANK);                   // [RULE_05]
		end else if ((state_nxt == ext_mem_pkg::ST_TAIL) || (state_nxt == ext_mem_pkg::ST_IDLE)) begin
			addr_hi_out <= 8'h00;
			addr_hi_oe  <= 1'b0;                                                                 // [RULE_03]
		end else begin
			addr_hi_out <= addr_hi_r;
			addr_hi_oe  <= drive_hi_r;
		end
	end

	// read and write strobes, active low, only inside the strobe phase
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rd_out_n <= 1'b1;
			wr_out_n <= 1'b1;
		end else begin
			rd_out_n <= !((state_nxt == ext_mem_pkg::ST_STROBE) && !write_r);                     // [RULE_02]
			wr_out_n <= !((state_nxt == ext_mem_pkg::ST_STROBE) && write_r);                      // [RULE_02]
		end
	end

	// core handshake; read data sampled on the last strobe cycle while the memory still drives
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			move_busy  <= 1'b0;
			move_done  <= 1'b0;
			move_rdata <= 8'h00;
		end else begin
			move_busy <= (state_nxt != ext_mem_pkg::ST_IDLE);                                     // [RULE_10]
			move_done <= phase_end && (state_r == ext_mem_pkg::ST_TAIL);                          // [RULE_10]
			if (phase_end && (state_r == ext_mem_pkg::ST_STROBE) && !write_r) begin
				move_rdata <= ad_in;
			end
		end
	end

endmodule : ext_mem_mux_timing

// >>> testbench/ext_mem_sva.sv
// checker for pin timing of the external memory timing controller
`timescale 1ns/100ps
module ext_mem_sva (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        reset_n,
	// core side
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_wr,
	input wire logic [7:0]  sfr_wdata,
	input wire logic [7:0]  ext_if_config,
	input wire logic [7:0]  bank_page_register,
	input wire logic        move_valid,
	input wire logic        move_wide,
	input wire logic [15:0] move_addr,
	input wire logic        move_busy,
	input wire logic        move_done,
	// memory pins
	input wire logic [7:0]  ad_out,
	input wire logic        ad_oe,
	input wire logic [7:0]  addr_hi_out,
	input wire logic        addr_hi_oe,
	input wire logic        ale_out,
	input wire logic        rd_out_n,
	input wire logic        wr_out_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic [7:0] tm_r, ts_r, hi_r, lo_r, ac_r, wc_r, hc_r, bc_r, al;
	logic       nb_r, stb, acc;
	assign stb = rd_out_n & wr_out_n;
	assign acc = move_valid & ~move_busy & (ext_if_config[4:2] inside {3'h1, 3'h2, 3'h3});
	assign al  = {6'h00, ext_if_config[1:0]} + 8'h01;
	// register mirror; a snapshot per access since writes mid-access must not apply
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tm_r <= 8'hff;
		end else if (sfr_wr && sfr_addr == 8'haa) begin
			tm_r <= sfr_wdata;
		end
	end
	// per-access expectations
	always_ff @(posedge clk_sys) begin
		if (acc) begin
			ts_r <= tm_r;
			lo_r <= move_addr[7:0];
			hi_r <= move_wide ? move_addr[15:8] : bank_page_register;
			nb_r <= ~move_wide & (ext_if_config[4:2] != 3'h2);
		end
	end
	// phase counters, cleared at the start of what they measure
	always_ff @(posedge clk_sys) begin
		ac_r <= ale_out ? 8'h00 : ac_r + 8'h01;
		wc_r <= stb ? 8'h00 : wc_r + 8'h01;
		hc_r <= stb ? hc_r + 8'h01 : 8'h00;
		bc_r <= move_busy ? bc_r + 8'h01 : 8'h00;
	end
	chk_ale_start: assert property (acc |=> ale_out && ad_oe && move_busy)
		else $error("access did not open with latch strobe");
	chk_low_addr: assert property (ale_out |-> ad_oe && ad_out == lo_r)
		else $error("low address wrong under latch strobe");
	chk_high_addr: assert property (addr_hi_oe |-> addr_hi_out == hi_r)
		else $error("upper address byte wrong");
	chk_high_free: assert property (move_busy && nb_r |-> !addr_hi_oe)
		else $error("upper address driven on narrow move");
	chk_setup_len: assert property ($fell(stb) |-> ac_r == al + ts_r[7:6])
		else $error("latch low plus setup length wrong");
	chk_strobe_len: assert property ($rose(stb) |-> wc_r == ts_r[5:2] + 8'h01)
		else $error("strobe width wrong");
	chk_hold_len: assert property ($fell(addr_hi_oe) |-> hc_r == ts_r[1:0])
		else $error("address hold length wrong");
	chk_move_len: assert property ($fell(move_busy) |-> move_done &&
		bc_r == 2 * al + ts_r[7:6] + ts_r[5:2] + ts_r[1:0] + 8'h05) else $error("move length wrong");
endmodule : ext_mem_sva
bind ext_mem_mux_timing ext_mem_sva u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .ext_if_config(ext_if_config), .move_valid(move_valid),
	.bank_page_register(bank_page_register), .move_wide(move_wide), .move_addr(move_addr),
	.move_busy(move_busy), .move_done(move_done), .ad_out(ad_out), .ad_oe(ad_oe), .ale_out(ale_out),
	.addr_hi_out(addr_hi_out), .addr_hi_oe(addr_hi_oe), .rd_out_n(rd_out_n), .wr_out_n(wr_out_n));

// >>> testbench/ext_mem_model.sv
// external memory with its address latch on the shared bus
`timescale 1ns/100ps
module ext_mem_model #(
	parameter logic [7:0] PORT_HI = 8'h00
) (
	// clock
	input  wire logic       clk_sys,
	// controller pins
	input  wire logic [7:0] ad_out,
	input  wire logic       ad_oe,
	input  wire logic [7:0] addr_hi_out,
	input  wire logic       addr_hi_oe,
	input  wire logic       ale_out,
	input  wire logic       rd_out_n,
	input  wire logic       wr_out_n,
	// shared bus back to the controller
	output logic      [7:0] ad_in
);
	logic [7:0]  lat_r;
	logic [7:0]  mem [65536];
	logic [15:0] a;
	// latch passes while the strobe is high and freezes once it falls
	always @(ale_out or ad_out) if (ale_out) lat_r = ad_out;
	// port latches supply the upper byte when the controller leaves it undriven
	assign a = {addr_hi_oe ? addr_hi_out : PORT_HI, lat_r};
	// a released bus shows the inverse of ad_out, which the controller zeroes on release, so stale data cannot match
	assign ad_in = ad_oe ? ad_out : (!rd_out_n ? mem[a] : ~ad_out);
	// write data taken on each clock with the write strobe low
	always @(posedge clk_sys) if (!wr_out_n) mem[a] <= ad_out;
endmodule : ext_mem_model

// >>> testbench/testbench.sv
// self-checking bench for the external memory timing controller
`timescale 1ns/100ps
module testbench;
	logic        clk_sys, reset_n, sfr_wr, move_valid, move_write, move_wide;
	logic        move_busy, move_done, ad_oe, addr_hi_oe, ale_out, rd_out_n, wr_out_n;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, ext_if_config, bank_page_register;
	logic [7:0]  move_wdata, move_rdata, ad_in, ad_out, addr_hi_out;
	logic [15:0] move_addr;
	int          mismatches, checked, cycles;
	logic [7:0]  tms [3] = '{8'h00, 8'h96, 8'h6d};
	ext_mem_mux_timing uut (.clk_sys(clk_sys), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext_if_config(ext_if_config), .move_wide(move_wide),
		.bank_page_register(bank_page_register), .move_valid(move_valid), .move_write(move_write),
		.move_addr(move_addr), .move_wdata(move_wdata), .move_busy(move_busy), .move_done(move_done),
		.move_rdata(move_rdata), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .addr_hi_out(addr_hi_out),
		.addr_hi_oe(addr_hi_oe), .ale_out(ale_out), .rd_out_n(rd_out_n), .wr_out_n(wr_out_n));
	ext_mem_model mem (.clk_sys(clk_sys), .ad_out(ad_out), .ad_oe(ad_oe), .addr_hi_out(addr_hi_out),
		.addr_hi_oe(addr_hi_oe), .ale_out(ale_out), .rd_out_n(rd_out_n), .wr_out_n(wr_out_n), .ad_in(ad_in));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic end_of_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// expected move length from timing byte and latch phase code
	function automatic int tt(input logic [7:0] tm, input logic [1:0] ac);
		return 2 * (ac + 1) + tm[7:6] + tm[5:2] + 1 + tm[1:0] + 4;
	endfunction : tt
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(posedge clk_sys);
		sfr_wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		sfr_addr <= a;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk(sfr_rdata, e);
	endtask : rreg
	// one move; request dropped at the edge that takes it; busy cycles counted, done pulse follows busy
	task automatic mv(input logic w, input logic wd, input logic [15:0] ad, input logic [7:0] d, input int t);
		int n;
		int b;
		@(posedge clk_sys);
		move_valid <= 1'b1;
		move_write <= w;
		move_wide  <= wd;
		move_addr  <= ad;
		move_wdata <= d;
		@(posedge clk_sys);
		move_valid <= 1'b0;
		n = 0;
		b = 0;
		do begin
			@(negedge clk_sys);
			n++;
			if (move_busy === 1'b1) b++;
		end while (move_done !== 1'b1 && n < 60);
		chk(16'(b), 16'(t));
		chk({15'h0000, move_done}, 16'h0001);
	endtask : mv
	// hang guard, far above the few hundred cycles the sequence needs
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		{reset_n, sfr_wr, move_valid, move_write, move_wide} <= 5'h00;
		{sfr_addr, sfr_wdata, ext_if_config, move_wdata, move_addr} <= 48'h0;
		bank_page_register <= 8'hc3;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		rreg(8'haa, 8'hff);
		rreg(8'h55, 8'h00);
		@(posedge clk_sys);
		move_valid <= 1'b1;
		repeat (2) @(posedge clk_sys);
		ext_if_config <= 8'h1c; // modes 1xx never reach off-chip memory either
		repeat (2) @(posedge clk_sys);
		move_valid    <= 1'b0;
		ext_if_config <= 8'h0f;
		@(negedge clk_sys);
		chk(move_busy, 16'h0000);
		mv(1'b1, 1'b1, 16'h1234, 8'h5c, 34);
		mv(1'b0, 1'b1, 16'h1234, 8'h00, 34);
		chk(move_rdata, 8'h5c);
		for (int i = 0; i < 3; i++) begin
			wreg(8'haa, tms[i]);
			ext_if_config <= {3'h0, 3'(i + 1), 2'(i)};
			rreg(8'haa, tms[i]);
			mv(1'b1, 1'b0, {8'h00, 8'(i)}, 8'ha0 + 8'(i), tt(tms[i], 2'(i)));
			mv(1'b0, 1'b1, {(i == 1) ? 8'hc3 : 8'h00, 8'(i)}, 8'h00, tt(tms[i], 2'(i)));
			chk(move_rdata, 8'ha0 + 8'(i));
		end
		wreg(8'hab, 8'h00);
		rreg(8'haa, 8'h6d);
		end_of_test();
	end
endmodule : testbench
